// *** sys_settings.sv ***
// system settings registers, deferred self-calibration and done output
//
// How it works
// - calibration request waits until measurement finishes
// - auto bit set selects automatic calibration
// - manual calibration accepted even in auto mode
// - current select 0.1A or 1A
// - key beep enable flag, set and readable
// - mains frequency auto, 50 or 60 only
// - panel lock blocks all front-panel key access
// - header flag cleared at power-up and reset command
// - done output rises when measurement completes
// - hold mode drops output at next trigger
// - pulse mode drops output after programmed width
// - pulse width 1 to 100 ms, 1 ms steps
`timescale 1ns/10ps
`default_nettype none

module sys_settings
  import sys_settings_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES  // shorten in simulation
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // measurement engine and external trigger pins
  input  wire logic        trigger_i,      // measurement start pin
  input  wire logic        meas_end_i,     // measurement finished pin
  input  wire logic        cal_done_i,     // calibration engine finished
  output logic             cal_start_o,    // one-cycle calibration start
  output logic             cal_auto_o,     // automatic calibration selected
  output logic             current_1a_o,   // low range current is 1A
  output logic [1:0]       mains_freq_select_o,
  output logic             header_en_o,    // prefix responses with header
  // front panel
  input  wire logic        key_press_i,    // panel key pulse
  output logic             key_accept_o,   // key passed to settings logic
  output logic             beep_o,         // beep for an accepted key
  // external i/o
  output logic             measure_done_output_o
);
  // ---------------- input synchronisers ----------------
  logic [2:0] sync1;       // first stage, read only by sync2
  logic [2:0] sync2;       // second stage, safe to use
  logic [2:0] sync_prev;   // previous synchronised value for edges
  logic       key_sync1;   // panel key first stage
  logic       key_sync2;   // panel key second stage

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1     <= 3'h0;
      sync2     <= 3'h0;
      sync_prev <= 3'h0;
      key_sync1 <= 1'b0;
      key_sync2 <= 1'b0;
    end else begin
      sync1     <= {cal_done_i, meas_end_i, trigger_i};
      sync2     <= sync1;
      sync_prev <= sync2;
      key_sync1 <= key_press_i;
      key_sync2 <= key_sync1;
    end
  end

  wire trig_rise = sync2[0] & ~sync_prev[0];  // new measurement starts
  wire end_rise  = sync2[1] & ~sync_prev[1];  // measurement complete
  wire cdone     = sync2[2] & ~sync_prev[2];  // calibration complete

  // ---------------- register state ----------------
  logic [7:0] ctrl;        // packed settings, fields per package
  logic [6:0] pulse_ms;    // done pulse width in milliseconds
  logic       cal_pend;    // calibration requested, not yet started
  logic       cal_busy;    // calibration running
  logic       measuring;   // between trigger and measurement end
  logic       err;         // sticky: a write carried a bad value
  logic       done_out;    // done output level

  // ---------------- bus decode ----------------
  wire        req      = cyc_i & stb_i;
  wire        wr_now   = req & we_i & ack_o & sel_i[0];  // write lands on ack
  wire        hit_ctrl = (adr_i == ADDR_CTRL);
  wire        hit_pw   = (adr_i == ADDR_PULSE);
  wire        hit_cmd  = (adr_i == ADDR_CMD);
  wire        hit_st   = (adr_i == ADDR_STATUS);
  wire [1:0]  wr_freq  = dat_i[CTRL_FREQ_HI:CTRL_FREQ_LO];
  wire        freq_bad = (wr_freq == FREQ_INVALID);
  wire [6:0]  wr_pw    = dat_i[6:0];
  wire        pw_bad   = (wr_pw < PULSE_MS_MIN) || (wr_pw > PULSE_MS_MAX) || (dat_i[7] != 1'b0);
  wire        wr_ctrl  = wr_now & hit_ctrl;
  wire        wr_pwr   = wr_now & hit_pw;
  wire        wr_cmd   = wr_now & hit_cmd;
  wire        cmd_cal  = wr_cmd & dat_i[CMD_CAL];
  wire        cmd_rst  = wr_cmd & dat_i[CMD_STD_RESET];
  wire        cmd_clr  = wr_cmd & dat_i[CMD_CLR_ERR];
  wire        bad_wr   = (wr_ctrl & freq_bad) | (wr_pwr & pw_bad);
  wire [7:0]  status   = {3'h0, err, done_out, measuring, cal_busy, cal_pend};

  // read mux; unmapped addresses and the command register read zero
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl} :
                       hit_pw   ? {25'h0, pulse_ms} :
                       hit_st   ? {24'h0, status} : 32'h0;

  // single-wait acknowledge: ack one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req & ~ack_o;
      dat_o <= rd_mux;
    end
  end

  // ---------------- settings ----------------
  // a bad frequency code leaves the old choice in place, other fields still land
  wire [1:0] keep_freq = freq_bad ? ctrl[CTRL_FREQ_HI:CTRL_FREQ_LO] : wr_freq;
  wire [7:0] next_ctrl = {dat_i[CTRL_MODE], dat_i[CTRL_HEADER], dat_i[CTRL_LOCK],
                          keep_freq, dat_i[CTRL_BEEP], dat_i[CTRL_CURRENT],
                          dat_i[CTRL_CAL_AUTO]};

  // settings store; standard reset clears the header flag and beats a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= CTRL_RESET;
      pulse_ms <= PULSE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (cmd_rst) begin
        ctrl[CTRL_HEADER] <= 1'b0;
      end
      if (wr_pwr && !pw_bad) begin
        pulse_ms <= wr_pw;
      end
    end
  end

  // sticky error flag; a new bad write wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err <= 1'b0;
    end else if (bad_wr) begin
      err <= 1'b1;
    end else if (cmd_clr) begin
      err <= 1'b0;
    end
  end

  // ---------------- measurement and calibration ----------------
  // measuring tracks trigger to end; end in the same cycle as a trigger wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      measuring <= 1'b0;
    end else if (end_rise) begin
      measuring <= 1'b0;
    end else if (trig_rise) begin
      measuring <= 1'b1;
    end
  end

  // calibration is deferred while a measurement runs, accepted in any mode
  wire cal_go = cal_pend & ~measuring & ~cal_busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_pend    <= 1'b0;
      cal_busy    <= 1'b0;
      cal_start_o <= 1'b0;
    end else begin
      cal_start_o <= cal_go;
      if (cmd_cal) begin
        cal_pend <= 1'b1;
      end else if (cal_go) begin
        cal_pend <= 1'b0;
      end
      if (cal_go) begin
        cal_busy <= 1'b1;
      end else if (cdone) begin
        cal_busy <= 1'b0;
      end
    end
  end

  // ---------------- done output ----------------
  wire pulse_mode = (done_mode_t'(ctrl[CTRL_MODE]) == MODE_PULSE);
  wire pulse_end;  // timer elapsed

  done_pulse_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (end_rise),
    .width_ms_i (pulse_ms),
    .expired_o  (pulse_end)
  );

  // assert at completion; hold mode drops at next trigger, pulse at expiry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_out <= 1'b0;
    end else if (end_rise) begin
      done_out <= 1'b1;
    end else if (!pulse_mode && trig_rise) begin
      done_out <= 1'b0;
    end else if (pulse_mode && pulse_end) begin
      done_out <= 1'b0;
    end
  end

  // ---------------- front panel ----------------
  logic key_prev;  // previous key level for edge detect

  // lock swallows keys entirely, so no beep either
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_prev     <= 1'b0;
      key_accept_o <= 1'b0;
      beep_o       <= 1'b0;
    end else begin
      key_prev     <= key_sync2;
      key_accept_o <= key_sync2 & ~key_prev & ~ctrl[CTRL_LOCK];
      beep_o       <= key_sync2 & ~key_prev & ~ctrl[CTRL_LOCK] & ctrl[CTRL_BEEP];
    end
  end

  // ---------------- setting outputs ----------------
  assign cal_auto_o            = ctrl[CTRL_CAL_AUTO];
  assign current_1a_o          = ctrl[CTRL_CURRENT];
  assign mains_freq_select_o   = ctrl[CTRL_FREQ_HI:CTRL_FREQ_LO];
  assign header_en_o           = ctrl[CTRL_HEADER];
  assign measure_done_output_o = done_out;
endmodule // sys_settings

`default_nettype wire

// *** done_pulse_timer.sv ***
// shared constants and the millisecond pulse timer for the done output
`timescale 1ns/10ps
`default_nettype none

package sys_settings_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_PULSE  = 4'h4;
  localparam logic [3:0] ADDR_CMD    = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // control register fields
  localparam int CTRL_CAL_AUTO  = 0;
  localparam int CTRL_CURRENT   = 1;
  localparam int CTRL_BEEP      = 2;
  localparam int CTRL_FREQ_LO   = 3;
  localparam int CTRL_FREQ_HI   = 4;
  localparam int CTRL_LOCK      = 5;
  localparam int CTRL_HEADER    = 6;
  localparam int CTRL_MODE      = 7;
  // command register fields
  localparam int CMD_CAL        = 0;
  localparam int CMD_STD_RESET  = 1;
  localparam int CMD_CLR_ERR    = 2;
  // status register fields
  localparam int ST_CAL_PEND    = 0;
  localparam int ST_CAL_BUSY    = 1;
  localparam int ST_MEASURING   = 2;
  localparam int ST_DONE_OUT    = 3;
  localparam int ST_ERR         = 4;
  // mains frequency codes
  localparam logic [1:0] FREQ_AUTO    = 2'h0;
  localparam logic [1:0] FREQ_50      = 2'h1;
  localparam logic [1:0] FREQ_60      = 2'h2;
  localparam logic [1:0] FREQ_INVALID = 2'h3;
  // pulse width limits in milliseconds
  localparam logic [6:0] PULSE_MS_MIN = 7'h01;
  localparam logic [6:0] PULSE_MS_MAX = 7'h64;
  // reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [6:0] PULSE_RESET = 7'h01;
  // timing: clock period and one millisecond, both in nanoseconds
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int SUB_W         = 22;
  // done output modes
  typedef enum logic {MODE_HOLD, MODE_PULSE} done_mode_t;
endpackage

module done_pulse_timer
  import sys_settings_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,     // restart the timer
  input  wire logic [6:0] width_ms_i,  // width sampled at start
  output logic            expired_o    // one-cycle pulse at the end
);
  logic [SUB_W-1:0] sub;       // cycles within the current millisecond
  logic [6:0]       ms_left;   // whole milliseconds still to run
  logic             running;   // timer active
  wire              ms_tick = running && (sub == SUB_W'(CYC_PER_MS - 1));
  wire              last_ms = (ms_left == 7'h01);

  // count down whole milliseconds; a restart always wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub       <= '0;
      ms_left   <= '0;
      running   <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (start_i) begin
        sub     <= '0;
        ms_left <= width_ms_i;
        running <= 1'b1;
      end else if (ms_tick) begin
        sub     <= '0;
        ms_left <= ms_left - 7'h01;
        if (last_ms) begin
          running   <= 1'b0;
          expired_o <= 1'b1;
        end
      end else if (running) begin
        sub <= sub + SUB_W'(1);
      end
    end
  end
endmodule // done_pulse_timer

`default_nettype wire

// *** sys_settings_sva.sv ***
// port assertions for the system settings block
`timescale 1ns/10ps
`default_nettype none
module sys_settings_sva
  import sys_settings_pkg::*;
#(parameter int unsigned CYC_PER_MS = MS_CYCLES) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        trigger_i,
  input wire logic        meas_end_i,
  input wire logic        key_accept_o,
  input wire logic        beep_o,
  input wire logic        cal_auto_o,
  input wire logic        current_1a_o,
  input wire logic [1:0]  mains_freq_select_o,
  input wire logic        measure_done_output_o
);
  logic [7:0]  ctrl_q;  // shadow of the control byte
  logic [6:0]  wid_q;   // shadow of the pulse width
  logic [15:0] hi_cnt;  // cycles the done output has stood high
  wire  logic  wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  wire  logic [31:0] lim = 32'(wid_q) * 32'(CYC_PER_MS);
  // shadows land on the ack edge, as the block's own write does
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      wid_q  <= PULSE_RESET;
    end else if (wr && adr_i == ADDR_CTRL) begin
      ctrl_q <= dat_i[7:0];
    end else if (wr && adr_i == ADDR_PULSE && dat_i[7:0] > 8'h00 && dat_i[7:0] < 8'h65) begin
      wid_q <= dat_i[6:0];
    end
  end
  // high-time counter; a restart mid-pulse is not modelled
  always_ff @(posedge clk_i) begin
    hi_cnt <= (rst_i || !measure_done_output_o) ? 16'h0000 : hi_cnt + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence hold_idle;
    (!ctrl_q[CTRL_MODE] && measure_done_output_o && !trigger_i) [*6];
  endsequence
  ack_after_req_a: assert property (bus_req |=> ack_o) else $error("no ack");
  ack_one_cycle_a: assert property (ack_o |=> !ack_o) else $error("long ack");
  done_on_end_a: assert property ($rose(meas_end_i) |-> ##[2:5] measure_done_output_o)
    else $error("done late");
  hold_until_trig_a: assert property (hold_idle |=> measure_done_output_o)
    else $error("hold dropped");
  pulse_width_a: assert property ($fell(measure_done_output_o) && ctrl_q[CTRL_MODE]
    |-> hi_cnt >= lim && hi_cnt <= lim + 4) else $error("pulse width");
  lock_blocks_a: assert property (key_accept_o |-> !$past(ctrl_q[CTRL_LOCK])) else $error("lock");
  beep_flag_a: assert property (beep_o |-> $past(ctrl_q[CTRL_BEEP] && !ctrl_q[CTRL_LOCK]))
    else $error("beep");
  flags_follow_a: assert property (cal_auto_o == ctrl_q[CTRL_CAL_AUTO]
    && current_1a_o == ctrl_q[CTRL_CURRENT]) else $error("flags");
  freq_legal_a: assert property (mains_freq_select_o != FREQ_INVALID) else $error("freq");
endmodule // sys_settings_sva
bind sys_settings sys_settings_sva #(.CYC_PER_MS(CYC_PER_MS)) i_sys_settings_sva (.clk_i,
  .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .trigger_i, .meas_end_i,
  .key_accept_o, .beep_o, .cal_auto_o, .current_1a_o, .mains_freq_select_o,
  .measure_done_output_o);
`default_nettype wire

// *** meas_engine_model.sv ***
// model of the measurement and calibration engines on the pin side
`timescale 1ns/10ps
`default_nettype none
module meas_engine_model (
  input  wire logic clk_i,
  input  wire logic go_i,         // start one measurement
  input  wire logic slow_i,       // long measurement
  input  wire logic cal_start_i,  // calibration request from the block
  output logic      trigger_o,
  output logic      meas_end_o,
  output logic      cal_done_o
);
  logic [7:0] mcnt = 8'h00;  // measurement step, 0 when idle
  logic [7:0] len  = 8'h0c;  // measurement length in cycles
  logic [7:0] ccnt = 8'h00;  // calibration step, 0 when idle
  // pins stand four cycles so the two-flop sync always sees them
  assign trigger_o  = mcnt != 8'h00 && mcnt < 8'h05;
  assign meas_end_o = mcnt != 8'h00 && mcnt > len - 8'h04;
  assign cal_done_o = ccnt > 8'h10;
  // step counters
  always @(posedge clk_i) begin
    if (go_i) begin
      mcnt <= 8'h01;
      len  <= slow_i ? 8'h3c : 8'h0c;
    end else if (mcnt != 8'h00) begin
      mcnt <= (mcnt == len) ? 8'h00 : mcnt + 8'h01;
    end
    if (cal_start_i) begin
      ccnt <= 8'h01;
    end else if (ccnt != 8'h00) begin
      ccnt <= (ccnt == 8'h14) ? 8'h00 : ccnt + 8'h01;
    end
  end
endmodule // meas_engine_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the system settings block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sys_settings_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, key_press_i = 0, go = 0, slow = 0;
  logic [3:0]  adr_i = 0, sel_i = 0;
  logic [31:0] dat_i = 0, rd;
  logic [31:0] dat_o;
  logic ack_o, trigger_i, meas_end_i, cal_done_i, cal_start_o, cal_auto_o, current_1a_o;
  logic header_en_o, key_accept_o, beep_o, measure_done_output_o;
  logic [1:0]  mains_freq_select_o;
  int error_cnt = 0, n_checks = 0, cycles = 0, n;
  always #12.5 clk_i = ~clk_i;
  // ten cycles per millisecond keeps pulse widths short
  sys_settings #(.CYC_PER_MS(10)) i_sys_settings (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .trigger_i, .meas_end_i, .cal_done_i,
    .cal_start_o, .cal_auto_o, .current_1a_o, .mains_freq_select_o, .header_en_o,
    .key_press_i, .key_accept_o, .beep_o, .measure_done_output_o);
  meas_engine_model i_meas_engine_model (.clk_i, .go_i(go), .slow_i(slow),
    .cal_start_i(cal_start_o), .trigger_o(trigger_i), .meas_end_o(meas_end_i),
    .cal_done_o(cal_done_i));
  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic press(input logic ea, input logic eb);
    logic a, b;
    a = 0;
    b = 0;
    key_press_i <= 1'b1;
    repeat (6) begin
      @(posedge clk_i);
      a |= key_accept_o;
      b |= beep_o;
    end
    key_press_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("key_accept", 32'(ea), 32'(a));
    chk("beep", 32'(eb), 32'(b));
  endtask
  task automatic measure(input logic s);
    go   <= 1'b1;
    slow <= s;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  // wait while the done output equals v, bounded
  task automatic wait_done(input logic v);
    n = 0;
    while (measure_done_output_o === v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic t_regs();
    wb(ADDR_CTRL, 0, 0); chk("ctrl_rst", 0, rd);
    wb(ADDR_PULSE, 0, 0); chk("pulse_rst", 32'(PULSE_RESET), rd);
    for (int f = 0; f < 3; f++) begin
      wb(ADDR_CTRL, 1, 32'((f << 3) + f + 1));
      wb(ADDR_CTRL, 0, 0); chk("ctrl", 32'((f << 3) + f + 1), rd);
      chk("freq", 32'(f), 32'(mains_freq_select_o));
      chk("auto", 32'((f + 1) & 1), 32'(cal_auto_o));
      chk("cur", 32'(((f + 1) >> 1) & 1), 32'(current_1a_o));
    end
    wb(ADDR_CTRL, 1, 32'h18); wb(ADDR_CTRL, 0, 0); chk("freq_bad", 32'h10, rd);
    wb(ADDR_STATUS, 0, 0); chk("err", 1, 32'(rd[ST_ERR]));
    wb(ADDR_CTRL, 1, 32'h01, 4'he); wb(ADDR_CTRL, 0, 0); chk("sel", 32'h10, rd);
    wb(ADDR_PULSE, 1, 0); wb(ADDR_PULSE, 1, 32'h65);
    wb(ADDR_PULSE, 0, 0); chk("pulse_bad", 1, rd);
    wb(ADDR_PULSE, 1, 32'h64); wb(ADDR_PULSE, 0, 0); chk("pulse", 32'h64, rd);
    wb(4'h2, 0, 0); chk("unmapped", 0, rd);
    wb(ADDR_CMD, 1, 32'h4); wb(ADDR_CMD, 0, 0); chk("cmd_rd", 0, rd);
    wb(ADDR_STATUS, 0, 0); chk("err_clr", 0, 32'(rd[ST_ERR]));
  endtask
  task automatic t_keys_hdr();
    wb(ADDR_CTRL, 1, 32'h04); press(1, 1);
    wb(ADDR_CTRL, 1, 32'h00); press(1, 0);
    wb(ADDR_CTRL, 1, 32'h24); press(0, 0);
    wb(ADDR_CTRL, 1, 32'h40); @(posedge clk_i); chk("hdr", 1, 32'(header_en_o));
    wb(ADDR_CMD, 1, 32'h2); @(posedge clk_i); chk("hdr_rst", 0, 32'(header_en_o));
  endtask
  task automatic t_pulse();
    wb(ADDR_PULSE, 1, 32'h2);
    wb(ADDR_CTRL, 1, 32'h80);
    measure(0);
    wait_done(0);
    wait_done(1); chk("pulse_len", 1, 32'(n >= 20 && n <= 24));
  endtask
  task automatic t_cal();
    wb(ADDR_CTRL, 1, 32'h81);
    measure(1);
    repeat (10) @(posedge clk_i);
    wb(ADDR_CMD, 1, 32'h1);
    wb(ADDR_STATUS, 0, 0); chk("pending", 32'h5, rd & 32'h7);
    n = 0;
    while (cal_start_o !== 1'b1 && n < 150) begin
      @(posedge clk_i);
      n++;
    end
    chk("cal_start", 1, 32'(n < 150));
    chk("cal_late", 1, 32'(i_meas_engine_model.mcnt == 0 || i_meas_engine_model.mcnt > 56));
    repeat (30) @(posedge clk_i);
    wb(ADDR_STATUS, 0, 0); chk("cal_idle", 0, rd & 32'h3);
    repeat (40) @(posedge clk_i);
  endtask
  task automatic t_hold();
    wb(ADDR_CTRL, 1, 32'h00);
    measure(0);
    wait_done(0);
    repeat (20) @(posedge clk_i);
    chk("hold", 1, 32'(measure_done_output_o));
    wb(ADDR_STATUS, 0, 0); chk("st_done", 1, 32'(rd[ST_DONE_OUT]));
    measure(0);
    wait_done(1); chk("hold_drop", 1, 32'(n <= 8));
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_keys_hdr();
    t_pulse();
    t_cal();
    t_hold();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
